// ---- src/i2c_target.v ----
// i2c target: byte-addressed register port with pointer auto increment
// assumes scl and sda already synchronous to clock and free of glitches
`timescale 1ns/100ps
module i2c_target (
  // system
  input  wire       clock,
  input  wire       reset,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe,
  // target address
  input  wire [6:0] own_addr,
  // register access
  output reg  [7:0] reg_addr,
  output reg  [7:0] wr_data,
  output reg        wr_stb,
  input  wire [7:0] rd_data
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_RX   = 3'h3;
  localparam ST_TX   = 3'h4;
  localparam ST_MACK = 3'h5;

  reg       scl_q;
  reg       sda_q;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg       rw_q;
  reg       ptr_phase_q;
  reg       nxt_tx_q;
  reg       armed_q;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start    = scl_in & scl_q & sda_q & ~sda_in;
  wire stop     = scl_in & scl_q & ~sda_q & sda_in;
  // the scl fall that follows a start carries no bits; only a fall after a rise ends a byte
  wire byte_end = scl_fall & armed_q & (bit_q == 3'h0);

  always @(posedge clock) begin
    scl_q  <= scl_in;
    sda_q  <= sda_in;
    wr_stb <= 1'b0;
    if (reset) begin
      state_q     <= ST_IDLE;
      bit_q       <= 3'h0;
      sh_q        <= 8'h00;
      rw_q        <= 1'b0;
      ptr_phase_q <= 1'b0;
      nxt_tx_q    <= 1'b0;
      armed_q     <= 1'b0;
      sda_oe      <= 1'b0;
      reg_addr    <= 8'h00;
      wr_data     <= 8'h00;
    end else if (start) begin
      state_q <= ST_ADDR;
      bit_q   <= 3'h0;
      armed_q <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (stop) begin
      state_q <= ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_q    <= {sh_q[6:0], sda_in};
            bit_q   <= bit_q + 3'h1;
            armed_q <= 1'b1;
          end
          if (byte_end && state_q == ST_ADDR && sh_q[7:1] == own_addr) begin
            rw_q        <= sh_q[0];
            ptr_phase_q <= ~sh_q[0];
            nxt_tx_q    <= sh_q[0];
            sda_oe      <= 1'b1;
            state_q     <= ST_ACK;
          end else if (byte_end && state_q == ST_ADDR) begin
            state_q <= ST_IDLE;
          end else if (byte_end) begin
            if (ptr_phase_q) begin
              reg_addr <= sh_q;
            end else begin
              wr_data  <= sh_q;
              wr_stb   <= 1'b1;
            end
            ptr_phase_q <= 1'b0;
            sda_oe      <= 1'b1;
            nxt_tx_q    <= 1'b0;
            state_q     <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (nxt_tx_q) begin
              sh_q    <= rd_data;
              sda_oe  <= ~rd_data[7];
              state_q <= ST_TX;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= ST_RX;
            end
            bit_q <= 3'h0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              sda_oe   <= 1'b0;
              reg_addr <= reg_addr + 8'h01;
              state_q  <= ST_MACK;
            end else begin
              sda_oe <= ~sh_q[6];
              sh_q   <= {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            state_q <= sda_in ? ST_IDLE : ST_ACK;
            nxt_tx_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (wr_stb) begin
        reg_addr <= reg_addr + 8'h01;
      end
    end
  end
endmodule // i2c_target

// ---- src/led_sink_blink_control.v ----
// led sink configuration registers and blink pattern generator
// assumes i2c pins synchronous to clock; master enable and on/off state from elsewhere
//
// Overview of operation
// - i2c target address chosen by option bit
// - full-scale selector off, 3.2, 6.4, 12.8mA
// - normal phase: on first, then off
// - period 0.5s to 8s, half-second steps
// - on fraction is (code+1)/16 in normal phase, (15-code)/16 in inverted phase
// - inverted phase: off first, then on
// - active only with master enable and on-state
// - 5-bit brightness scales chosen full-scale current
`timescale 1ns/100ps
`include "led_sink_defs.vh"
module led_sink_blink_control #(
  parameter SLOT_CYCLES = `SLOT_CYCLES
) (
  // system
  input  wire       clock,
  input  wire       reset,
  input  wire       system_reset_event,
  // i2c
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe_q,
  input  wire       addr_option,
  // shared enables
  input  wire       sink_master_enable,
  input  wire       onoff_is_on,
  // sink drive
  output reg        sink_on_q,
  output reg  [1:0] sink_full_scale_sel_q,
  output reg  [4:0] sink_brightness_code_q
);
  reg  [7:0]  range_q;
  reg  [7:0]  blink_q;
  reg  [23:0] slot_cnt_q;
  reg  [7:0]  tick_q;
  reg  [7:0]  rd_q;
  reg         addr_opt_q;
  wire [7:0]  reg_addr;
  wire [7:0]  wr_data;
  wire        wr_stb;
  wire        sda_oe;

  assign sda_out = 1'b0;

  always @(posedge clock) begin
    if (reset) begin
      addr_opt_q <= 1'b0;
    end else begin
      addr_opt_q <= addr_option;
    end
  end

  i2c_target u_i2c (
    .clock    (clock),
    .reset    (reset),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe   (sda_oe),
    .own_addr (addr_opt_q ? `I2C_ADDR_OPT1 : `I2C_ADDR_OPT0),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .wr_stb   (wr_stb),
    .rd_data  (rd_q)
  );

  // registers; the system reset event restores defaults
  always @(posedge clock) begin
    sda_oe_q <= reset ? 1'b0 : sda_oe;
    if (reset || system_reset_event) begin
      range_q <= `RST_RANGE_PHASE_BRT;
      blink_q <= `RST_PERIOD_DUTY;
    end else if (wr_stb) begin
      if (reg_addr == `REG_RANGE_PHASE_BRT) begin
        range_q <= wr_data;
      end
      if (reg_addr == `REG_PERIOD_DUTY) begin
        blink_q <= wr_data;
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      rd_q <= 8'h00;
    end else begin
      case (reg_addr)
        `REG_RANGE_PHASE_BRT: rd_q <= range_q;
        `REG_PERIOD_DUTY:     rd_q <= blink_q;
        default:              rd_q <= 8'h00;
      endcase
    end
  end

  // period is (sel+1) half seconds, each split in 16 slots
  wire       active   = sink_master_enable & onoff_is_on
                        & (range_q[`FS_HI:`FS_LO] != `FS_OFF);
  wire [7:0] period_t = {blink_q[`PER_HI:`PER_LO], 4'hF};
  wire [7:0] on_t     = {4'h0, blink_q[`DUTY_HI:`DUTY_LO]} + 8'h01;
  wire [7:0] tick_sc  = tick_q / ({4'h0, blink_q[`PER_HI:`PER_LO]} + 8'h01);
  wire       in_duty  = tick_sc < on_t;

  always @(posedge clock) begin
    if (reset || !active) begin
      slot_cnt_q <= 24'h000000;
      tick_q     <= 8'h00;
    end else if (slot_cnt_q == SLOT_CYCLES - 1) begin
      slot_cnt_q <= 24'h000000;
      tick_q     <= (tick_q >= period_t) ? 8'h00 : tick_q + 8'h01;
    end else begin
      slot_cnt_q <= slot_cnt_q + 24'h000001;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      sink_on_q              <= 1'b0;
      sink_full_scale_sel_q  <= 2'h0;
      sink_brightness_code_q <= 5'h00;
    end else begin
      sink_on_q              <= active & (in_duty ^ range_q[`INV_BIT]);
      sink_full_scale_sel_q  <= range_q[`FS_HI:`FS_LO];
      sink_brightness_code_q <= range_q[`BRT_HI:`BRT_LO];
    end
  end
endmodule // led_sink_blink_control

// ---- src/led_sink_defs.vh ----
// constants for the led sink blink and configuration block
// assumes a 40 MHz system clock and an i2c bus on an open-drain pin pair
`ifndef LED_SINK_DEFS_VH
`define LED_SINK_DEFS_VH

// register addresses and reset values
`define REG_RANGE_PHASE_BRT  8'h41
`define REG_PERIOD_DUTY      8'h44
`define RST_RANGE_PHASE_BRT  8'h04
`define RST_PERIOD_DUTY      8'h0F
// field positions
`define FS_HI                7
`define FS_LO                6
`define INV_BIT              5
`define BRT_HI               4
`define BRT_LO               0
`define PER_HI               7
`define PER_LO               4
`define DUTY_HI              3
`define DUTY_LO              0
// i2c target addresses selected by the address option bit
`define I2C_ADDR_OPT0        7'h48
`define I2C_ADDR_OPT1        7'h40
// timing: one sixteenth of the half-second step
`define STEP_MS              500
`define CLOCK_HZ             40000000
`define SLOT_CYCLES          ((`CLOCK_HZ / 1000) * `STEP_MS / 16)
// full-scale selector codes
`define FS_OFF               2'h0

`endif

// ---- test/led_load.sv ----
// led load model: counts clocks in which the sink lights the led
// assumes sink_on_q is registered on clock
`timescale 1ns/100ps
module led_load (
  // drive
  input  wire       clock,
  input  wire       clear,
  input  wire       sink_on_q,
  input  wire [1:0] sink_full_scale_sel_q,
  // light
  output integer    lit_cycles
);
  always @(posedge clock) begin
    if (clear)
      lit_cycles <= 0;
    else if (sink_on_q && sink_full_scale_sel_q != 2'h0)
      lit_cycles <= lit_cycles + 1;
  end
endmodule // led_load

// ---- test/led_sink_blink_control_test.sv ----
// bench: i2c writes, defaults and blink pattern of the led sink block
// assumes a 4-clock slot
`timescale 1ns/100ps
`include "led_sink_defs.vh"
module led_sink_blink_control_test;
  reg        clock, reset, sys_rst, scl, sda_h, opt, men, st, clr, ack;
  reg  [7:0] m [0:255];
  reg  [7:0] rb;
  integer    n_errors, n_compared, lf, lit, i, k, p, d;
  wire       sda_oe_q, on;
  wire [1:0] fs;
  wire [4:0] brt;
  wire       sda = sda_h & ~sda_oe_q;
  wire [6:0] own = opt ? `I2C_ADDR_OPT1 : `I2C_ADDR_OPT0;
  led_sink_blink_control #(.SLOT_CYCLES(4)) uut (.clock(clock), .reset(reset),
    .system_reset_event(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_q(sda_oe_q),
    .addr_option(opt), .sink_master_enable(men), .onoff_is_on(st), .sink_on_q(on),
    .sink_full_scale_sel_q(fs), .sink_brightness_code_q(brt));
  led_load led (.clock(clock), .clear(clr), .sink_on_q(on), .sink_full_scale_sel_q(fs),
    .lit_cycles(lit));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %0t: got %0h want %0h", $time, seen, exp);
      end
    end
  endtask
  function [31:0] lfsr(input [31:0] v);
    begin
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    end
  endfunction
  task final_report;
    begin
      if (n_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task half(input s, input c);
    begin
      sda_h = s;
      scl = c;
      repeat (4) @(negedge clock);
    end
  endtask
  // eight data bits then the acknowledge bit
  task send(input [7:0] b);
    reg [8:0] w;
    begin
      w = {b, 1'b1};
      for (i = 8; i >= 0; i = i - 1) begin
        half(w[i], 0);
        half(w[i], 1);
        ack = !sda;
        half(w[i], 0);
      end
    end
  endtask
  task wr(input [6:0] dev, input [7:0] ptr, input [7:0] b0, input [7:0] b1);
    begin
      half(1, 1);
      half(0, 1);
      half(0, 0);
      send({dev, 1'b0});
      check(ack, dev == own);
      if (dev == own) begin
        send(ptr);
        send(b0);
        send(b1);
        m[ptr] = b0;
        m[ptr + 8'h01] = b1;
      end
      half(0, 0);
      half(0, 1);
      half(1, 1);
    end
  endtask
  // pointer write, repeated start, one byte read with a closing nack
  task rd(input [7:0] ptr, output [7:0] b);
    integer j;
    begin
      half(1, 1);
      half(0, 1);
      half(0, 0);
      send({own, 1'b0});
      send(ptr);
      half(1, 0);
      half(1, 1);
      half(0, 1);
      half(0, 0);
      send({own, 1'b1});
      for (j = 7; j >= 0; j = j - 1) begin
        half(1, 0);
        half(1, 1);
        b[j] = sda;
        half(1, 0);
      end
      half(1, 0);
      half(1, 1);
      half(1, 0);
      half(0, 0);
      half(0, 1);
      half(1, 1);
    end
  endtask
  task blink;
    begin
      men = 0;
      repeat (2) @(negedge clock);
      men = 1;
      repeat (2) @(negedge clock);
      check(on, m[65][7:6] != 2'h0 && !m[65][5]);
      clr = 1;
      @(negedge clock);
      clr = 0;
      p = m[68][7:4] + 1;
      d = m[68][3:0] + 1;
      repeat (64 * p) @(negedge clock);
      check(lit, (m[65][7:6] != 2'h0) * 4 * p * (m[65][5] ? 16 - d : d));
      st = 0;
      repeat (2) @(negedge clock);
      check(on, 0);
      st = 1;
    end
  endtask
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    reset = 1;
    sys_rst = 0;
    scl = 1;
    sda_h = 1;
    opt = 0;
    men = 1;
    st = 1;
    clr = 0;
    n_errors = 0;
    n_compared = 0;
    lf = 98735;
    m[65] = 8'h04;
    m[68] = 8'h0F;
    repeat (3) @(negedge clock);
    reset = 0;
    repeat (2) @(negedge clock);
    for (k = 0; k < 5; k = k + 1) begin
      check(brt, m[65][4:0]);
      check(fs, m[65][7:6]);
      blink;
      lf = lfsr(lf);
      opt = lf[9];
      wr(own ^ 7'h08, 8'h40, 8'h00, 8'h00);
      wr(own, 8'h40, lf[7:0], {k[1:0], lf[5:0]});
      wr(own, 8'h44, {lf[15:12], k == 0 ? 4'h0 : k == 3 ? 4'hF : lf[11:8]}, lf[7:0]);
      rd(8'h41, rb);
      check(rb, m[65]);
      rd(8'h44, rb);
      check(rb, m[68]);
      rd(8'h40, rb);
      check(rb, 8'h00);
    end
    sys_rst = 1;
    @(negedge clock);
    sys_rst = 0;
    m[65] = 8'h04;
    repeat (2) @(negedge clock);
    check(brt, m[65][4:0]);
    check(fs, 2'h0);
    final_report;
  end
endmodule // led_sink_blink_control_test

// ---- test/led_sink_properties.sv ----
// checker: sink drive and bus pin relations of the led sink block
// assumes only the block's ports; bound at the foot
`timescale 1ns/100ps
module led_sink_properties #(parameter SLOT_CYCLES = 4) (
  // system
  input wire       clock,
  input wire       reset,
  input wire       system_reset_event,
  // bus
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe_q,
  // sink
  input wire       sink_master_enable,
  input wire       onoff_is_on,
  input wire       sink_on_q,
  input wire [1:0] sink_full_scale_sel_q,
  input wire [4:0] sink_brightness_code_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_range_off_dark: assert property (sink_full_scale_sel_q == 2'h0 |-> !sink_on_q)
    else $error("lit with range off");
  a_master_gate: assert property (!sink_master_enable |=> !sink_on_q)
    else $error("lit without enable");
  a_onoff_gate: assert property (!onoff_is_on |=> !sink_on_q)
    else $error("lit in off state");
  a_rise_cause: assert property ($rose(sink_on_q) |-> $past(onoff_is_on))
    else $error("bad rise");
  a_system_reset_event_default: assert property (system_reset_event |-> ##2 sink_brightness_code_q == 5'h04)
    else $error("no default");
  a_reset_default: assert property ($fell(reset) |=> sink_brightness_code_q == 5'h04)
    else $error("no default");
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_ack_scl_low: assert property ($rose(sda_oe_q) |-> !scl_in)
    else $error("sda moved with scl high");
  c_blink: cover property ($rose(sink_on_q));
  c_ack: cover property ($rose(sda_oe_q));
  c_system_reset_event: cover property (system_reset_event);
endmodule // led_sink_properties
bind led_sink_blink_control led_sink_properties #(.SLOT_CYCLES(SLOT_CYCLES)) chk (.clock,
  .reset, .system_reset_event, .scl_in, .sda_out, .sda_oe_q, .sink_master_enable,
  .onoff_is_on, .sink_on_q, .sink_full_scale_sel_q, .sink_brightness_code_q);
